// >>> pkg/pwm_pkg.sv
package pwm_pkg;
    // Register byte addresses
    localparam logic [7:0] addr_period_limit   = 8'h00;
    localparam logic [7:0] addr_timer_ctrl     = 8'h04;
    localparam logic [7:0] addr_duty_high_bits = 8'h08;
    localparam logic [7:0] addr_unit_ctrl      = 8'h0c;
    localparam logic [7:0] addr_duty_shadow    = 8'h10;
    localparam logic [7:0] addr_period_counter = 8'h14;
    localparam logic [7:0] addr_flag_reg       = 8'h18;
    localparam logic [7:0] addr_pin_direction  = 8'h1c;
    localparam logic [7:0] addr_sleep_ctrl     = 8'h20;
    // Field positions
    localparam int timer_run_pos  = 2;
    localparam int prescale_lo    = 0;
    localparam int duty_low_lo    = 4;
    localparam int mode_lo        = 0;
    localparam int flag_pos       = 1;
    // Reset values
    localparam logic [7:0] period_limit_rst = 8'hff;
    localparam logic [7:0] ctrl_rst         = 8'h00;
    localparam logic       direction_rst    = 1'b1;
    // Mode encodings: 11xx selects pulse mode
    localparam logic [1:0] pulse_mode_hi = 2'h3;
    typedef enum logic [1:0] {
        presc_1  = 2'b00,
        presc_4  = 2'b01,
        presc_16 = 2'b10,
        presc_16b = 2'b11
    } prescale_type;
endpackage

// >>> pkg/tick_if.sv
interface tick_if;
    logic       tick;
    logic [1:0] low_bits;
    logic       running;
    modport source (output tick, output low_bits, input running);
    modport sink   (input tick, input low_bits, output running);
endinterface

// >>> rtl/pwm_prescaler.sv
module pwm_prescaler
    import pwm_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire prescale_type sel,
    tick_if.source            tk
);
    logic [5:0] count;
    logic [5:0] next_count;
    logic [5:0] limit;

    always_comb begin
        unique case (sel)
            presc_1:  limit = 6'h03;
            presc_4:  limit = 6'h0f;
            default:  limit = 6'h3f;
        endcase
        next_count = count;
        if (tk.running) begin
            next_count = (count == limit) ? 6'h00 : count + 6'h01;
        end
    end

    // Four phases per count, each one prescale period of clocks long; two extra low bits form the time base
    always_comb begin
        tk.tick = tk.running && (count == limit);
        unique case (sel)
            presc_1:  tk.low_bits = count[1:0];
            presc_4:  tk.low_bits = count[3:2];
            default:  tk.low_bits = count[5:4];
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 6'h00;
        end else begin
            count <= next_count;
        end
    end
endmodule

// >>> rtl/pwm_compare.sv
module pwm_compare (
    // Time base and duty
    input  wire logic [9:0] time_base,
    input  wire logic [9:0] duty_latched,
    input  wire logic [7:0] period_limit,
    // Result
    output logic            match,
    output logic            duty_zero
);
    logic [9:0] period_len;
    always_comb begin
        period_len = {period_limit, 2'b11};
        // No clearing match when duty exceeds the period
        match      = (time_base == duty_latched) && (duty_latched <= period_len);
        duty_zero  = (duty_latched == 10'h000);
    end
endmodule

// >>> rtl/standard_pwm_output.sv
// Summary of operation
// - Period is (limit+1) times 4 times prescale
// - Counter clears after reaching period limit
// - Pin set at period start unless zero
// - Duty latched into shadow at boundary
// - Duty is 8 high plus 2 low bits
// - Duty writes take effect next period
// - Shadow read-only while pulse mode active
// - Time base is counter plus two bits
// - Pin cleared when time base matches duty
// - Duty above period leaves pin unchanged
// - Resolution follows period limit, ten max
// - Postscaler never affects pulse period
// - Prescaler divides by 1, 4, 16
// - Sleep freezes prescaler and counter; registers stay writable
// - Pin driven only when direction is output
// - Zero unit control releases the pin
// - Reset restores registers, pin to input
//
// Decided for this implementation: register access over APB and the register offsets.
module standard_pwm_output
    import pwm_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Output pin
    output logic             pwm_out_pin,
    output logic             pwm_out_oe
);
    import pwm_pkg::*;

    tick_if tk ();

    logic [7:0] period_limit;
    logic [7:0] timer_ctrl;
    logic [7:0] duty_high_bits;
    logic [7:0] unit_ctrl;
    logic [7:0] duty_shadow;
    logic [1:0] duty_latch;
    logic [7:0] period_counter;
    logic       period_match_flag;
    logic       pin_direction;
    logic       sleep;
    logic       pin_level;
    logic       next_pin_level;
    logic [7:0] next_period_limit;
    logic [7:0] next_timer_ctrl;
    logic [7:0] next_duty_high_bits;
    logic [7:0] next_unit_ctrl;
    logic [7:0] next_duty_shadow;
    logic [1:0] next_duty_latch;
    logic [7:0] next_period_counter;
    logic       next_period_match_flag;
    logic       next_pin_direction;
    logic       next_sleep;
    logic [31:0] next_prdata;
    logic       next_pready;
    logic       next_pslverr;
    logic       next_pwm_out_pin;
    logic       next_pwm_out_oe;
    logic       wr;
    logic       rd;
    logic       pulse_mode;
    logic       boundary;
    logic       match;
    logic       duty_zero;
    logic [9:0] time_base;
    logic       known_addr;

    // Write strobes and period start
    logic       wr_limit;
    logic       wr_timer;
    logic       wr_duty;
    logic       wr_unit;
    logic       wr_shadow;
    logic       wr_counter;
    logic       wr_flag;
    logic       wr_dir;
    logic       wr_sleep;
    logic       period_start;
    logic       next_period_start;

    function automatic logic [31:0] zext8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    pwm_prescaler u_presc (
        .pclk    (pclk),
        .presetn (presetn),
        .sel     (prescale_type'(timer_ctrl[prescale_lo +: 2])),
        .tk      (tk.source)
    );

    pwm_compare u_cmp (
        .time_base    (time_base),
        .duty_latched ({duty_shadow, duty_latch}),
        .period_limit (period_limit),
        .match        (match),
        .duty_zero    (duty_zero)
    );

    always_comb begin
        pulse_mode = (unit_ctrl[mode_lo + 2 +: 2] == pulse_mode_hi);
        // Prescaler counts only while running and awake
        tk.running = timer_ctrl[timer_run_pos] && !sleep;
        time_base  = {period_counter, tk.low_bits};
        boundary   = tk.tick && (period_counter == period_limit);
    end

    // Bus decode: a write lands at the access edge, where pready is high
    always_comb begin
        wr         = psel && penable && pwrite && pready;
        rd         = psel && !penable;
        known_addr = (paddr <= addr_sleep_ctrl) && (paddr[1:0] == 2'b00);
        wr_limit   = wr && (paddr == addr_period_limit);
        wr_timer   = wr && (paddr == addr_timer_ctrl);
        wr_duty    = wr && (paddr == addr_duty_high_bits);
        wr_unit    = wr && (paddr == addr_unit_ctrl);
        wr_shadow  = wr && (paddr == addr_duty_shadow);
        wr_counter = wr && (paddr == addr_period_counter);
        wr_flag    = wr && (paddr == addr_flag_reg);
        wr_dir     = wr && (paddr == addr_pin_direction);
        wr_sleep   = wr && (paddr == addr_sleep_ctrl);
    end

    // Configuration registers
    always_comb begin
        next_period_limit   = period_limit;
        next_timer_ctrl     = timer_ctrl;
        next_duty_high_bits = duty_high_bits;
        next_unit_ctrl      = unit_ctrl;
        next_pin_direction  = pin_direction;
        next_sleep          = sleep;
        if (wr_limit) begin
            next_period_limit = pwdata[7:0];
        end
        if (wr_timer) begin
            next_timer_ctrl = pwdata[7:0];
        end
        // Duty writes land at once; the shadow takes them at the boundary
        if (wr_duty) begin
            next_duty_high_bits = pwdata[7:0];
        end
        if (wr_unit) begin
            next_unit_ctrl = pwdata[7:0];
        end
        if (wr_dir) begin
            next_pin_direction = pwdata[0];
        end
        if (wr_sleep) begin
            next_sleep = pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_limit   <= period_limit_rst;
            timer_ctrl     <= ctrl_rst;
            duty_high_bits <= ctrl_rst;
            unit_ctrl      <= ctrl_rst;
            pin_direction  <= direction_rst;
            sleep          <= 1'b0;
        end else begin
            period_limit   <= next_period_limit;
            timer_ctrl     <= next_timer_ctrl;
            duty_high_bits <= next_duty_high_bits;
            unit_ctrl      <= next_unit_ctrl;
            pin_direction  <= next_pin_direction;
            sleep          <= next_sleep;
        end
    end

    // Period counter and match flag
    always_comb begin
        next_period_counter    = period_counter;
        next_period_match_flag = period_match_flag;
        if (wr_counter) begin
            next_period_counter = pwdata[7:0];
        end
        if (wr_flag && !pwdata[flag_pos]) begin
            next_period_match_flag = 1'b0;
        end
        if (tk.tick) begin
            next_period_counter = boundary ? 8'h00 : period_counter + 8'h01;
        end
        // A boundary in the cycle of a clear keeps the flag set
        if (boundary) begin
            next_period_match_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_counter    <= ctrl_rst;
            period_match_flag <= 1'b0;
        end else begin
            period_counter    <= next_period_counter;
            period_match_flag <= next_period_match_flag;
        end
    end

    // Double-buffered duty
    always_comb begin
        next_duty_shadow = duty_shadow;
        next_duty_latch  = duty_latch;
        // Software may load the shadow only outside pulse mode
        if (wr_shadow && !pulse_mode) begin
            next_duty_shadow = pwdata[7:0];
        end
        if (boundary && pulse_mode) begin
            next_duty_shadow = duty_high_bits;
            next_duty_latch  = unit_ctrl[duty_low_lo +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_shadow <= ctrl_rst;
            duty_latch  <= 2'h0;
        end else begin
            duty_shadow <= next_duty_shadow;
            duty_latch  <= next_duty_latch;
        end
    end

    // Pin waveform, one cycle behind the time base for set and clear alike
    always_comb begin
        // Sleep holds a pending period start until counting resumes
        next_period_start = period_start;
        if (tk.running) begin
            next_period_start = boundary;
        end
        next_pin_level = pin_level;
        if (!pulse_mode) begin
            next_pin_level = 1'b0;
        end else if (period_start && tk.running) begin
            // Latched duty decides whether the new period starts high
            next_pin_level = !duty_zero;
        end else if (match && tk.running) begin
            next_pin_level = 1'b0;
        end
        next_pwm_out_pin = next_pin_level;
        next_pwm_out_oe  = pulse_mode && !next_pin_direction && (next_unit_ctrl != 8'h00);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_start <= 1'b0;
            pin_level    <= 1'b0;
            pwm_out_pin  <= 1'b0;
            pwm_out_oe   <= 1'b0;
        end else begin
            period_start <= next_period_start;
            pin_level    <= next_pin_level;
            pwm_out_pin  <= next_pwm_out_pin;
            pwm_out_oe   <= next_pwm_out_oe;
        end
    end

    // APB answer: setup answered in the next cycle, no wait states
    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !known_addr;
        next_prdata  = prdata;
        if (rd) begin
            unique case (paddr)
                addr_period_limit:   next_prdata = zext8(period_limit);
                addr_timer_ctrl:     next_prdata = zext8(timer_ctrl);
                addr_duty_high_bits: next_prdata = zext8(duty_high_bits);
                addr_unit_ctrl:      next_prdata = zext8(unit_ctrl);
                addr_duty_shadow:    next_prdata = zext8(duty_shadow);
                addr_period_counter: next_prdata = zext8(period_counter);
                addr_flag_reg:       next_prdata = {30'h0, period_match_flag, 1'b0};
                addr_pin_direction:  next_prdata = {31'h0, pin_direction};
                addr_sleep_ctrl:     next_prdata = {31'h0, sleep};
                default:             next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule

// >>> verification/pwm_chk_sva.sv
module pwm_chk (
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pin
    input wire logic        pwm_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] wr_age;
    logic       bad;
    logic       wr_ok;
    assign bad = paddr > 8'h20 || paddr[1:0] != 2'h0;
    assign wr_ok = pready && pwrite && !bad;
    // Cycles since the last write, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wr_age <= 3'h7;
        else if (pready && pwrite) wr_age <= 3'h0;
        else if (wr_age != 3'h7) wr_age <= wr_age + 3'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("setup not answered");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_unmapped_a: assert property (pready && bad |-> pslverr)
        else $error("bad address not refused");
    err_mapped_a: assert property (pready && !bad |-> !pslverr)
        else $error("good address refused");
    bad_read_a: assert property (pready && !pwrite && bad |-> prdata == 32'h0)
        else $error("bad read not zero");
    oe_release_a: assert property (
        wr_ok && paddr == 8'h0c && pwdata[7:0] == 8'h00 |-> ##[1:3] !pwm_out_oe)
        else $error("pin not released");
    oe_input_a: assert property (
        wr_ok && paddr == 8'h1c && pwdata[0] |-> ##[1:3] !pwm_out_oe)
        else $error("driver on while input");
    oe_cause_a: assert property ($rose(pwm_out_oe) |-> wr_age <= 3'h3)
        else $error("driver on without write");
endmodule
bind standard_pwm_output pwm_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwm_out_oe);

// >>> verification/pwm_load.sv
module pwm_load (
    // Pin side
    input wire logic        pclk,
    input wire logic        pwm_out_pin,
    input wire logic        pwm_out_oe,
    // Measurements: lengths in clock cycles, rises as a count of rising edges
    output logic     [15:0] high_len,
    output logic     [15:0] period_len,
    output logic     [7:0]  rises = 8'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        line;
    logic        prev = 1'b0;
    logic [15:0] cnt = 16'h0;
    // Pull-down load: an undriven line reads low
    assign line = pwm_out_oe & pwm_out_pin;
    always @(posedge pclk) begin
        cnt <= cnt + 16'h1;
        prev <= line;
        if (line && !prev) begin
            period_len <= cnt;
            cnt <= 16'h1;
            rises <= rises + 8'h1;
        end
        if (!line && prev) high_len <= cnt;
    end
endmodule

// >>> verification/standard_pwm_output_bench.sv
module standard_pwm_output_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import pwm_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pwm_out_pin;
    logic        pwm_out_oe;
    logic [15:0] high_len;
    logic [15:0] period_len;
    logic [7:0]  rises;
    logic        err;
    logic [31:0] rv;
    logic [7:0]  lim;
    logic [9:0]  dty;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          seed = 54;
    always #2.5 pclk = ~pclk;
    standard_pwm_output u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pwm_out_pin, .pwm_out_oe);
    pwm_load u_load (.pclk, .pwm_out_pin, .pwm_out_oe, .high_len, .period_len, .rises);
    task give_verdict;
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic int pres(input logic [1:0] p);
        return p == 2'b00 ? 1 : (p == 2'b01 ? 4 : 16);
    endfunction
    task wait_flag;
        do apb(1'b0, addr_flag_reg, 32'h0); while (rv[flag_pos] !== 1'b1);
    endtask
    task run(input logic [7:0] l, input logic [1:0] p, input logic [9:0] d);
        logic [7:0]  r0;
        logic [31:0] a;
        int          per;
        per = (l + 1) * 4 * pres(p);
        apb(1'b1, addr_pin_direction, 32'h1);
        apb(1'b1, addr_timer_ctrl, 32'h0);
        apb(1'b1, addr_period_counter, 32'h0);
        apb(1'b1, addr_period_limit, {24'h0, l});
        apb(1'b1, addr_unit_ctrl, {26'h0, d[1:0], 4'hc});
        apb(1'b1, addr_duty_high_bits, {24'h0, d[9:2]});
        apb(1'b1, addr_flag_reg, 32'h0);
        apb(1'b1, addr_timer_ctrl, {25'h0, 4'($random(seed)), 1'b1, p});
        wait_flag;
        apb(1'b1, addr_pin_direction, 32'h0);
        @(posedge pclk);
        chk("oe", 32'h1, {31'h0, pwm_out_oe});
        repeat (3 * per + 20) @(posedge pclk);
        if (d == 10'h0 || d >= 4 * (l + 1)) begin
            r0 = rises;
            repeat (per + 4) @(posedge pclk);
            chk("rises", {24'h0, r0}, {24'h0, rises});
            chk("pin", {31'h0, d != 10'h0}, {31'h0, pwm_out_pin});
        end else begin
            chk("period", 32'(per), {16'h0, period_len});
            chk("high", 32'(d * pres(p)), {16'h0, high_len});
        end
        // Freeze, then try the duty path while no boundary can occur
        apb(1'b1, addr_sleep_ctrl, 32'h1);
        apb(1'b0, addr_period_counter, 32'h0);
        a = rv;
        repeat (40) @(posedge pclk);
        apb(1'b0, addr_period_counter, 32'h0);
        chk("count", a, rv);
        apb(1'b1, addr_duty_high_bits, {24'h0, ~d[9:2]});
        apb(1'b1, addr_duty_shadow, 32'h5a);
        apb(1'b0, addr_duty_shadow, 32'h0);
        chk("shadow", {24'h0, d[9:2]}, rv);
        apb(1'b1, addr_sleep_ctrl, 32'h0);
        apb(1'b1, addr_flag_reg, 32'h0);
        wait_flag;
        apb(1'b0, addr_duty_shadow, 32'h0);
        chk("latched", {24'h0, ~d[9:2]}, rv);
        apb(1'b1, addr_unit_ctrl, 32'h0);
        @(posedge pclk);
        chk("release", 32'h0, {31'h0, pwm_out_oe});
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 40000) begin
            fail_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("oe_rst", 32'h0, {31'h0, pwm_out_oe});
        apb(1'b0, addr_period_limit, 32'h0);
        chk("limit_rst", {24'h0, period_limit_rst}, rv);
        apb(1'b0, addr_pin_direction, 32'h0);
        chk("dir_rst", {31'h0, direction_rst}, rv);
        apb(1'b0, addr_unit_ctrl, 32'h0);
        chk("ctrl_rst", {24'h0, ctrl_rst}, rv);
        apb(1'b1, 8'h24, 32'hff);
        chk("wr_err", 32'h1, {31'h0, err});
        apb(1'b0, 8'h24, 32'h0);
        chk("rd_err", 32'h1, {31'h0, err});
        chk("rd_zero", 32'h0, rv);
        for (int k = 0; k < 6; k++) begin
            lim = 8'({$random(seed)} % 6 + 2);
            dty = 10'({$random(seed)} % (4 * (lim + 1) - 1) + 1);
            if (k == 4) dty = 10'h0;
            if (k == 5) dty = 10'(4 * (lim + 1));
            run(lim, 2'(k % 4), dty);
        end
        give_verdict;
    end
endmodule
